// >>> rtl/glue_pkg.sv
package glue_pkg;
   // Card layout
   localparam int NUM_CTL = 2;                    // Controllers on the card
   localparam int STRAP_BITS = 9;                 // Option straps per controller
   localparam int BASE_BITS = 5;                  // Board base width
   // Strap positions inside one controller's slice; 1 means fitted
   localparam int S_PB_LO_OUT = 0;                // Port B bits 0-3 drive outward
   localparam int S_PB_HI_OUT = 1;                // Port B bits 4-7 drive outward
   localparam int S_BIDIR = 2;                    // Port A bidirectional request
   localparam int S_PA_OUT = 3;                   // Port A output select
   localparam int S_PA_IN = 4;                    // Port A input select
   localparam int S_PORT_A_STROBE_POL = 5;                 // Port A strobe polarity
   localparam int S_PORT_B_STROBE_POL = 6;                 // Port B strobe polarity
   localparam int S_PORT_A_READY_OUT_POL = 7;                 // Port A ready polarity
   localparam int S_PORT_B_READY_OUT_POL = 8;                 // Port B ready polarity
   // Host I/O address fields
   localparam int A_CTL = 2;                      // Controller select bit
   localparam int A_PORT = 1;                     // Port select bit
   localparam int A_CTRL = 0;                     // Data or control bit
   // APB register map, byte addresses
   localparam logic [7:0] OFS_VECTOR0 = 8'h00;    // First controller vector
   localparam logic [7:0] OFS_VECTOR1 = 8'h04;    // Second controller vector
   localparam logic [7:0] OFS_STATUS = 8'h08;     // Card status, faults W1C
   localparam logic [7:0] VECTOR_RESET = 8'h00;   // Vector reset value
   // Status fields
   localparam int ST_OUTWARD = 0;                 // [1:0] port A drives outward
   localparam int ST_REQ = 2;                     // [3:2] controller requesting
   localparam int ST_FAULT = 4;                   // [5:4] forbidden chain pair seen
   localparam int ST_BASE = 8;                    // [12:8] decoded board base
   // Bidirectional port A buffer direction, one-hot
   typedef enum logic [1:0] {
      DIR_OUT = 2'b01,
      DIR_IN = 2'b10
   } dir_t;
endpackage

// >>> rtl/port_if.sv
interface port_if;
   import glue_pkg::*;
   logic [STRAP_BITS-1:0] cfg;   // Option straps of one controller
   logic a_strobe_pin;           // Port A strobe from peripheral
   logic b_strobe_pin;           // Port B strobe from peripheral
   logic a_ready_ctl;            // Port A ready from controller
   logic b_ready_ctl;            // Port B ready from controller
   logic a_strobe_ctl;           // Port A strobe to controller
   logic b_strobe_ctl;           // Port B strobe to controller
   logic a_ready_pin;            // Port A ready to peripheral
   logic b_ready_pin;            // Port B ready to peripheral
   logic a_drive;                // Port A buffer drives outward
   logic a_receive;              // Port A buffer receives inward
   logic b_lo_drive;             // Port B low half drives outward
   logic b_hi_drive;             // Port B high half drives outward
   modport top (output cfg, a_strobe_pin, b_strobe_pin, a_ready_ctl, b_ready_ctl,
                input a_strobe_ctl, b_strobe_ctl, a_ready_pin, b_ready_pin,
                a_drive, a_receive, b_lo_drive, b_hi_drive);
   modport port (input cfg, a_strobe_pin, b_strobe_pin, a_ready_ctl, b_ready_ctl,
                 output a_strobe_ctl, b_strobe_ctl, a_ready_pin, b_ready_pin,
                 a_drive, a_receive, b_lo_drive, b_hi_drive);
endinterface

// >>> rtl/port_ctl.sv
module port_ctl
   import glue_pkg::*;
(
   input wire logic clock_i,   // Bus clock
   input wire logic rst_n_i,   // Sync reset, active low
   port_if.port p              // Straps and handshake lines of one controller
);
   dir_t dir;                  // Bidirectional buffer direction
   dir_t next_dir;
   logic next_a_strobe_ctl;
   logic next_b_strobe_ctl;
   logic next_a_ready_pin;
   logic next_b_ready_pin;
   logic next_a_drive;
   logic next_a_receive;
   logic bidir_ok;             // Bidirectional mode honoured

   // Next values of every handshake output and of the port A direction
   always_comb begin
      // An absent strap (0) inverts, a fitted one passes unchanged
      next_a_strobe_ctl = p.a_strobe_pin ^ ~p.cfg[S_PORT_A_STROBE_POL];
      next_b_strobe_ctl = p.b_strobe_pin ^ ~p.cfg[S_PORT_B_STROBE_POL];
      next_a_ready_pin = p.a_ready_ctl ^ ~p.cfg[S_PORT_A_READY_OUT_POL];
      next_b_ready_pin = p.b_ready_ctl ^ ~p.cfg[S_PORT_B_READY_OUT_POL];
      // Bidirectional only with both fixed straps open
      bidir_ok = p.cfg[S_BIDIR] & ~p.cfg[S_PA_OUT] & ~p.cfg[S_PA_IN];
      next_dir = dir;
      if (bidir_ok) begin
         // Corrected strobes are active low at the controller
         if (!next_a_strobe_ctl) begin
            next_dir = DIR_IN;
         end else if (!next_b_strobe_ctl) begin
            next_dir = DIR_OUT;
         end
      end else begin
         next_dir = DIR_OUT;   // Parked so a later bidir start is known
      end
      // Fixed straps first; both fitted or both open without bidir disables
      if (p.cfg[S_PA_OUT] && !p.cfg[S_PA_IN]) begin
         next_a_drive = 1'b1;
         next_a_receive = 1'b0;
      end else if (p.cfg[S_PA_IN] && !p.cfg[S_PA_OUT]) begin
         next_a_drive = 1'b0;
         next_a_receive = 1'b1;
      end else if (bidir_ok) begin
         next_a_drive = (next_dir == DIR_OUT);
         next_a_receive = (next_dir == DIR_IN);
      end else begin
         // Never drive against a peripheral on an unclear setting
         next_a_drive = 1'b0;
         next_a_receive = 1'b0;
      end
   end

   // Register outputs; port B halves follow their straps directly
   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         dir <= DIR_OUT;
         p.a_strobe_ctl <= 1'b1;
         p.b_strobe_ctl <= 1'b1;
         p.a_ready_pin <= 1'b0;
         p.b_ready_pin <= 1'b0;
         p.a_drive <= 1'b0;
         p.a_receive <= 1'b0;
         p.b_lo_drive <= 1'b0;
         p.b_hi_drive <= 1'b0;
      end else begin
         dir <= next_dir;
         p.a_strobe_ctl <= next_a_strobe_ctl;
         p.b_strobe_ctl <= next_b_strobe_ctl;
         p.a_ready_pin <= next_a_ready_pin;
         p.b_ready_pin <= next_b_ready_pin;
         p.a_drive <= next_a_drive;
         p.a_receive <= next_a_receive;
         p.b_lo_drive <= p.cfg[S_PB_LO_OUT];
         p.b_hi_drive <= p.cfg[S_PB_HI_OUT];
      end
   end
endmodule

// >>> rtl/card_glue.sv
// Contract
// - First controller port A direction from straps
// - First controller bidirectional only with straps open
// - Second controller port A direction from straps
// - Second controller port A strobe polarity strap
// - First controller port A strobe polarity strap
// - Port B strobes each own polarity strap
// - Second controller port B ready polarity
// - First controller port B ready polarity
// - Port A readies each own polarity strap
// - Respond only when upper five bits match
// - Bits 2,1,0 pick controller, port, control
// - Open address strap compares as one
// - No straps gives window F8 to FF
// - Shared bus buffers, decode alone selects controller
// - Second controller chained below first
// - Chained devices resolve priority via enables
// - Enable pair meaning; in low, out high forbidden
// - Only top requester supplies vector on acknowledge
// - Board joins backplane chain as one unit
// - Bidirectional buffer turns on A/B strobes
// - Port B nibble direction per strap
// - Bidirectional honoured only with fixed straps open
//
// Local design decisions: the address map and register access over APB.
module card_glue
   import glue_pkg::*;
(
   input wire logic clock_i,                                 // Bus clock
   input wire logic rst_n_i,                                 // Sync reset, active low
   // APB register port
   input wire logic [7:0] paddr_i,                           // APB byte address
   input wire logic psel_i,                                  // APB select
   input wire logic penable_i,                               // APB access phase
   input wire logic pwrite_i,                                // APB write
   input wire logic [31:0] pwdata_i,                         // APB write data
   output logic [31:0] prdata_o,                             // APB read data
   output logic pready_o,                                    // APB ready
   output logic pslverr_o,                                   // APB error
   // Host processor bus, sampled as synchronous
   input wire logic [7:0] io_addr_i,                         // Low address byte
   input wire logic io_req_n_i,                              // I/O request, low
   input wire logic mem_req_n_i,                             // Memory request, low
   input wire logic intack_n_i,                              // Int acknowledge, low
   input wire logic rd_n_i,                                  // Read strobe, low
   output logic [NUM_CTL-1:0] ctl_select_n_o,                // Controller selects, low
   output logic port_b_select_o,                             // 0 port A, 1 port B
   output logic control_select_o,                            // 0 data, 1 control
   output logic bus_buf_en_n_o,                              // Shared buffer enable, low
   output logic bus_buf_to_host_o,                           // Buffer faces the host
   output logic [7:0] vector_o,                              // Vector to data bus
   output logic vector_oe_o,                                 // Vector drive enable
   // Straps, 1 means fitted, static
   input wire logic [BASE_BITS-1:0] base_address_straps_i,   // Board base straps
   input wire logic [NUM_CTL*STRAP_BITS-1:0] handshake_option_straps_i, // Option straps
   // Interrupt priority chain
   input wire logic backplane_priority_in_i,                 // Priority from board above
   output logic backplane_priority_out_o,                    // Priority to board below
   output logic [NUM_CTL-1:0] chain_enable_in_o,             // Enable into controllers
   input wire logic [NUM_CTL-1:0] chain_enable_out_i,        // Enable out of controllers
   // Peripheral handshake and buffer control, per controller
   input wire logic [NUM_CTL-1:0] port_a_strobe_i,           // Port A strobe from peripheral
   input wire logic [NUM_CTL-1:0] port_b_strobe_i,           // Port B strobe from peripheral
   input wire logic [NUM_CTL-1:0] ctl_port_a_ready_i,        // Port A ready from controller
   input wire logic [NUM_CTL-1:0] ctl_port_b_ready_i,        // Port B ready from controller
   output logic [NUM_CTL-1:0] port_a_strobe_o,               // Port A strobe to controller
   output logic [NUM_CTL-1:0] port_b_strobe_o,               // Port B strobe to controller
   output logic [NUM_CTL-1:0] port_a_ready_out_o,            // Port A ready to peripheral
   output logic [NUM_CTL-1:0] port_b_ready_out_o,            // Port B ready to peripheral
   output logic [NUM_CTL-1:0] port_a_drive_o,                // Port A buffer outward
   output logic [NUM_CTL-1:0] port_a_receive_o,              // Port A buffer inward
   output logic [NUM_CTL-1:0] port_b_lo_drive_o,             // Port B bits 0-3 outward
   output logic [NUM_CTL-1:0] port_b_hi_drive_o              // Port B bits 4-7 outward
);

   // Fitted strap pulls an address bit to zero, open leaves it one
   function automatic logic [BASE_BITS-1:0] base_of(input logic [BASE_BITS-1:0] straps);
      base_of = ~straps;
   endfunction

   port_if pif[NUM_CTL]();                                   // Per-controller bundles

   logic [BASE_BITS-1:0] base;                               // Decoded board base
   logic card_hit;                                           // Valid I/O cycle to card
   logic [NUM_CTL-1:0] requesting;                           // Controller owns the chain
   logic [NUM_CTL-1:0] fault_now;                            // Forbidden pair this cycle
   logic [NUM_CTL-1:0] fault_prev;                           // Forbidden pair last cycle
   logic [NUM_CTL-1:0] fault;                                // Sticky chain faults
   logic [7:0] vector0;                                      // First controller vector
   logic [7:0] vector1;                                      // Second controller vector
   logic [NUM_CTL-1:0] outward;                              // Port A outward, status

   // Next-value signals
   logic [NUM_CTL-1:0] next_ctl_select_n;
   logic next_port_b_select;
   logic next_control_select;
   logic next_bus_buf_en_n;
   logic next_bus_buf_to_host;
   logic [7:0] next_vector;
   logic next_vector_oe;
   logic [NUM_CTL-1:0] next_chain_enable_in;
   logic next_priority_out;
   logic [NUM_CTL-1:0] next_fault;
   logic [7:0] next_vector0;
   logic [7:0] next_vector1;
   logic [31:0] next_prdata;
   logic next_pready;
   logic next_pslverr;
   logic apb_setup;
   logic apb_done;
   logic mapped;

   // One port controller per I/O device
   generate
      for (genvar g = 0; g < NUM_CTL; g++) begin : g_port
         assign pif[g].cfg = handshake_option_straps_i[g*STRAP_BITS +: STRAP_BITS];
         assign pif[g].a_strobe_pin = port_a_strobe_i[g];
         assign pif[g].b_strobe_pin = port_b_strobe_i[g];
         assign pif[g].a_ready_ctl = ctl_port_a_ready_i[g];
         assign pif[g].b_ready_ctl = ctl_port_b_ready_i[g];
         // Module outputs are already flops; these are plain wires
         assign port_a_strobe_o[g] = pif[g].a_strobe_ctl;
         assign port_b_strobe_o[g] = pif[g].b_strobe_ctl;
         assign port_a_ready_out_o[g] = pif[g].a_ready_pin;
         assign port_b_ready_out_o[g] = pif[g].b_ready_pin;
         assign port_a_drive_o[g] = pif[g].a_drive;
         assign port_a_receive_o[g] = pif[g].a_receive;
         assign port_b_lo_drive_o[g] = pif[g].b_lo_drive;
         assign port_b_hi_drive_o[g] = pif[g].b_hi_drive;
         assign outward[g] = pif[g].a_drive;
         port_ctl u_port (
            .clock_i (clock_i),
            .rst_n_i (rst_n_i),
            .p (pif[g].port)
         );
      end
   endgenerate

   // Host address decode; one window of eight bytes
   always_comb begin
      base = base_of(base_address_straps_i);
      // Memory and acknowledge cycles never look like data access
      card_hit = !io_req_n_i && mem_req_n_i && intack_n_i
                 && (io_addr_i[7:3] == base);
      next_ctl_select_n = '1;
      if (card_hit) begin
         next_ctl_select_n[io_addr_i[A_CTL]] = 1'b0;
      end
      next_port_b_select = io_addr_i[A_PORT];
      next_control_select = io_addr_i[A_CTRL];
   end

   // Interrupt chain and vector supply
   always_comb begin
      // Board enters the chain as a whole, second device below first
      next_chain_enable_in[0] = backplane_priority_in_i;
      next_chain_enable_in[1] = chain_enable_out_i[0];
      next_priority_out = chain_enable_out_i[1];
      // In high with out low marks the requesting device
      requesting = chain_enable_in_o & ~chain_enable_out_i;
      // Chain allows at most one requester; lower index wins anyway
      next_vector_oe = !intack_n_i && (requesting != '0);
      next_vector = requesting[0] ? vector0 : vector1;
      // Shared buffer opens for card cycles and for the vector
      next_bus_buf_en_n = !(card_hit || next_vector_oe);
      next_bus_buf_to_host = next_vector_oe || (card_hit && !rd_n_i);
      // One-cycle skew in the registered chain would look forbidden,
      // so a fault counts only when the pair holds two cycles
      fault_now = ~chain_enable_in_o & chain_enable_out_i;
   end

   // APB slave: one wait state, then ready for one cycle
   always_comb begin
      apb_setup = psel_i && penable_i && !pready_o;
      apb_done = psel_i && penable_i && pready_o;
      mapped = (paddr_i == OFS_VECTOR0) || (paddr_i == OFS_VECTOR1)
               || (paddr_i == OFS_STATUS);
      next_pready = apb_setup;
      next_pslverr = apb_setup && !mapped;
      next_prdata = 32'h0000_0000;
      if (apb_setup && !pwrite_i) begin
         unique case (paddr_i)
            OFS_VECTOR0: next_prdata[7:0] = vector0;
            OFS_VECTOR1: next_prdata[7:0] = vector1;
            OFS_STATUS: begin
               next_prdata[ST_OUTWARD +: NUM_CTL] = outward;
               next_prdata[ST_REQ +: NUM_CTL] = requesting;
               next_prdata[ST_FAULT +: NUM_CTL] = fault;
               next_prdata[ST_BASE +: BASE_BITS] = base;
            end
            default: next_prdata = 32'h0000_0000;   // Unmapped reads zero
         endcase
      end
      next_vector0 = vector0;
      next_vector1 = vector1;
      next_fault = fault;
      if (apb_done && pwrite_i) begin
         if (paddr_i == OFS_VECTOR0) begin
            next_vector0 = pwdata_i[7:0];
         end
         if (paddr_i == OFS_VECTOR1) begin
            next_vector1 = pwdata_i[7:0];
         end
         if (paddr_i == OFS_STATUS) begin
            next_fault = fault & ~pwdata_i[ST_FAULT +: NUM_CTL];
         end
      end
      // A new fault wins over a clear in the same cycle
      next_fault = next_fault | (fault_now & fault_prev);
   end

   // All state and outputs registered here, except the port outputs registered in port_ctl
   always_ff @(posedge clock_i) begin
      if (!rst_n_i) begin
         ctl_select_n_o <= '1;
         port_b_select_o <= 1'b0;
         control_select_o <= 1'b0;
         bus_buf_en_n_o <= 1'b1;
         bus_buf_to_host_o <= 1'b0;
         vector_o <= 8'h00;
         vector_oe_o <= 1'b0;
         chain_enable_in_o <= '0;
         backplane_priority_out_o <= 1'b0;
         fault_prev <= '0;
         fault <= '0;
         vector0 <= VECTOR_RESET;
         vector1 <= VECTOR_RESET;
         prdata_o <= 32'h0000_0000;
         pready_o <= 1'b0;
         pslverr_o <= 1'b0;
      end else begin
         ctl_select_n_o <= next_ctl_select_n;
         port_b_select_o <= next_port_b_select;
         control_select_o <= next_control_select;
         bus_buf_en_n_o <= next_bus_buf_en_n;
         bus_buf_to_host_o <= next_bus_buf_to_host;
         vector_o <= next_vector;
         vector_oe_o <= next_vector_oe;
         chain_enable_in_o <= next_chain_enable_in;
         backplane_priority_out_o <= next_priority_out;
         fault_prev <= fault_now;
         fault <= next_fault;
         vector0 <= next_vector0;
         vector1 <= next_vector1;
         prdata_o <= next_prdata;
         pready_o <= next_pready;
         pslverr_o <= next_pslverr;
      end
   end
endmodule

// >>> tb/ctl_chain_model.sv
module ctl_chain_model (
   input wire logic [1:0] chain_enable_in_i,   // Enable into each controller
   input wire logic [1:0] want_i,              // Controller wants service
   output logic [1:0] chain_enable_out_o       // Enable out of each controller
);
   timeunit 1ns;
   timeprecision 1ps;
   // A requester blocks those below it; no enable in means out stays low
   assign chain_enable_out_o = chain_enable_in_i & ~want_i;
endmodule

// >>> tb/card_glue_sva.sv
module card_glue_sva
   import glue_pkg::*;
(
   input wire logic clock_i, rst_n_i, psel_i, penable_i, pready_o, io_req_n_i, mem_req_n_i,
   input wire logic intack_n_i, port_b_select_o, bus_buf_en_n_o, bus_buf_to_host_o, vector_oe_o,
   input wire logic backplane_priority_in_i, backplane_priority_out_o, rd_n_i,
   input wire logic [7:0] io_addr_i,
   input wire logic [BASE_BITS-1:0] base_address_straps_i,
   input wire logic [NUM_CTL*STRAP_BITS-1:0] handshake_option_straps_i,
   input wire logic [NUM_CTL-1:0] ctl_select_n_o, chain_enable_in_o, chain_enable_out_i,
   input wire logic [NUM_CTL-1:0] port_a_strobe_i, port_b_strobe_i, ctl_port_a_ready_i,
   input wire logic [NUM_CTL-1:0] ctl_port_b_ready_i, port_a_strobe_o, port_b_strobe_o,
   input wire logic [NUM_CTL-1:0] port_a_ready_out_o, port_b_ready_out_o, port_a_drive_o,
   input wire logic [NUM_CTL-1:0] port_a_receive_o, port_b_lo_drive_o, port_b_hi_drive_o
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clock_i); endclocking
   default disable iff (!rst_n_i);
   // Straps of both controllers, controller 1 in the upper bit
   wire logic [17:0] h = handshake_option_straps_i;
   wire logic [1:0] fo = {h[12], h[3]}, fi = {h[13], h[4]};
   wire logic hit = !io_req_n_i && mem_req_n_i && intack_n_i && io_addr_i[7:3] == ~base_address_straps_i;
   a_sel_hit: assert property (hit |=> ctl_select_n_o == ~(2'b01 << $past(io_addr_i[2]))
      && port_b_select_o == $past(io_addr_i[1]) && !bus_buf_en_n_o) else $error("bad select");
   a_sel_miss: assert property (!hit |=> ctl_select_n_o == 2'b11) else $error("stray select");
   a_strobe_pol: assert property (1 |=> port_a_strobe_o == $past(port_a_strobe_i ^ ~{h[14], h[5]})
      && port_b_strobe_o == $past(port_b_strobe_i ^ ~{h[15], h[6]})) else $error("strobe polarity");
   a_ready_pol: assert property (1 |=> port_a_ready_out_o == $past(ctl_port_a_ready_i ^ ~{h[16], h[7]})
      && port_b_ready_out_o == $past(ctl_port_b_ready_i ^ ~{h[17], h[8]})) else $error("ready polarity");
   a_fixed_dir: assert property (1 |=> ($past(fo ^ fi) & port_a_drive_o) == $past(fo & ~fi)
      && ($past(fo ^ fi) & port_a_receive_o) == $past(fi & ~fo)) else $error("port a direction");
   a_both_fixed: assert property (1 |=> ($past(fo & fi) & (port_a_drive_o | port_a_receive_o)) == 2'b00)
      else $error("both straps fitted yet buffer on");
   a_dir_excl: assert property ((port_a_drive_o & port_a_receive_o) == 2'b00) else $error("buffer fight");
   a_nibble_dir: assert property (1 |=> port_b_lo_drive_o == $past({h[9], h[0]})
      && port_b_hi_drive_o == $past({h[10], h[1]})) else $error("port b direction");
   a_chain_link: assert property (1 |=> chain_enable_in_o == $past({chain_enable_out_i[0], backplane_priority_in_i})
      && backplane_priority_out_o == $past(chain_enable_out_i[1])) else $error("chain link");
   a_vector_ack: assert property (!intack_n_i && |(chain_enable_in_o & ~chain_enable_out_i)
      |=> vector_oe_o && !bus_buf_en_n_o && bus_buf_to_host_o) else $error("no vector");
   a_vector_idle: assert property (intack_n_i |=> !vector_oe_o) else $error("stray vector");
   a_apb_wait: assert property (psel_i && !penable_i |=> !pready_o ##1 pready_o) else $error("apb wait");
   a_buf_dir: assert property (1 |=> bus_buf_to_host_o == $past(hit && !rd_n_i
      || !intack_n_i && |(chain_enable_in_o & ~chain_enable_out_i)))
      else $error("buffer direction");
endmodule

// >>> tb/testbench.sv
module testbench;
   import glue_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct {int due; logic [32:0] exp; logic [32:0] mask;} note_t;
   note_t gq[$];        // Expected glue outputs, oldest first
   logic [33:0] aq[$];  // Expected APB answers: write, error, data
   int error_cnt = 0, check_count = 0, cyc = 0;
   logic clock_i = 0, rst_n_i = 0, psel_i = 0, penable_i = 0, pwrite_i = 0, pready_o, pslverr_o;
   logic io_req_n_i = 1, mem_req_n_i = 1, intack_n_i = 1, rd_n_i = 1, backplane_priority_in_i = 0;
   logic port_b_select_o, control_select_o, bus_buf_en_n_o, bus_buf_to_host_o, vector_oe_o;
   logic backplane_priority_out_o;
   logic [7:0] paddr_i = 0, io_addr_i = 0, vector_o, v0, v1;
   logic [31:0] pwdata_i = 0, prdata_o;
   logic [4:0] base_address_straps_i = 0;
   logic [17:0] handshake_option_straps_i = 0;
   logic [1:0] port_a_strobe_i = 3, port_b_strobe_i = 3, ctl_port_a_ready_i = 0;
   logic [1:0] ctl_port_b_ready_i = 0, want = 0, ein = 0;
   logic [1:0] ctl_select_n_o, chain_enable_in_o, chain_enable_out_i, port_a_strobe_o;
   logic [1:0] port_b_strobe_o, port_a_ready_out_o, port_b_ready_out_o, port_a_drive_o;
   logic [1:0] port_a_receive_o, port_b_lo_drive_o, port_b_hi_drive_o;
   // Vector is only meaningful while driven, so it is masked otherwise
   wire logic [32:0] obs = {ctl_select_n_o, port_b_select_o, control_select_o, bus_buf_en_n_o,
      port_a_strobe_o, port_b_strobe_o, port_a_ready_out_o, port_b_ready_out_o, chain_enable_in_o,
      backplane_priority_out_o, port_b_lo_drive_o, port_b_hi_drive_o, port_a_drive_o,
      port_a_receive_o, vector_oe_o, vector_oe_o ? vector_o : 8'h00};
   card_glue i_card_glue (.*);
   ctl_chain_model i_ctl_chain_model (.chain_enable_in_i(chain_enable_in_o), .want_i(want),
      .chain_enable_out_o(chain_enable_out_i));
   always #2.5 clock_i = ~clock_i;
   task automatic complete_run();
      if (error_cnt == 0 && check_count > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task automatic chk_glue(input logic [32:0] seen, input logic [32:0] exp);
      check_count++;
      if (seen !== exp) begin error_cnt++; $display("MISMATCH glue exp %h seen %h", exp, seen); end
   endtask
   task automatic chk_apb(input logic [32:0] seen, input logic [32:0] exp);
      check_count++;
      if (seen !== exp) begin error_cnt++; $display("MISMATCH apb exp %h seen %h", exp, seen); end
   endtask
   task automatic note(input logic [32:0] e, input logic [32:0] m, input int lag);
      gq.push_back('{cyc + lag, e, m});
   endtask
   // One APB transfer; holds the request until pready is seen
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic e);
      @(posedge clock_i);
      aq.push_back({w, e, d});
      psel_i <= 1; penable_i <= 0; pwrite_i <= w; paddr_i <= a; pwdata_i <= d;
      @(posedge clock_i);
      penable_i <= 1;
      // No wait limit here; only the hang guard ends a stuck access
      do @(posedge clock_i); while (pready_o !== 1'b1);
      psel_i <= 0; penable_i <= 0;
   endtask
   // One random host, strap, handshake and chain cycle with its expected outputs
   task automatic step();
      logic [17:0] h; logic [7:0] a; logic [4:0] b; logic [3:0] c;
      logic [1:0] sa, sb, ra, rb, rq, r, fo, fi; logic hit, oe, pi;
      h = 18'($urandom) & ~18'h00804;  // Bidirectional off, direction stays stateless
      b = 5'($urandom); a = 8'($urandom); c = 4'($urandom);
      {sa, sb, ra, rb, rq, pi} = 11'($urandom);
      if (c[0]) a[7:3] = ~b;  // Bias toward hits
      handshake_option_straps_i <= h; base_address_straps_i <= b; io_addr_i <= a;
      io_req_n_i <= c[1]; intack_n_i <= c[2]; mem_req_n_i <= ~(c[3] & c[0]); rd_n_i <= c[3];
      port_a_strobe_i <= sa; port_b_strobe_i <= sb; ctl_port_a_ready_i <= ra;
      ctl_port_b_ready_i <= rb; want <= rq; backplane_priority_in_i <= pi;
      hit = !c[1] && c[2] && !(c[3] & c[0]) && a[7:3] == ~b;
      r = ein & rq; oe = !c[2] && |r;
      fo = {h[12], h[3]}; fi = {h[13], h[4]};
      note({hit ? ~(2'b01 << a[2]) : 2'b11, a[1], a[0], ~(hit | oe), sa ^ ~{h[14], h[5]},
         sb ^ ~{h[15], h[6]}, ra ^ ~{h[16], h[7]}, rb ^ ~{h[17], h[8]}, ein[0] & ~rq[0], pi,
         ein[1] & ~rq[1], {h[9], h[0]}, {h[10], h[1]}, fo & ~fi, fi & ~fo, oe,
         oe ? (r[0] ? v0 : v1) : 8'h00}, '1, 2);
      ein = {ein[0] & ~rq[0], pi};
   endtask
   // Result watchers
   always @(posedge clock_i) begin
      if (psel_i && penable_i && pready_o === 1'b1 && aq.size() > 0) begin
         logic [33:0] x;
         x = aq.pop_front();
         chk_apb({pslverr_o, x[33] ? 32'h0 : prdata_o}, {x[32], x[33] ? 32'h0 : x[31:0]});
      end
   end
   always @(posedge clock_i) begin
      #1;
      cyc++;
      while (gq.size() > 0 && gq[0].due == cyc) begin
         note_t n;
         n = gq.pop_front();
         chk_glue(obs & n.mask, n.exp & n.mask);
      end
   end
   initial begin
      void'($urandom(81));
      repeat (3) @(posedge clock_i);
      rst_n_i <= 1;
      v0 = 8'($urandom); v1 = 8'($urandom);
      apb(1, OFS_VECTOR0, {24'h0, v0}, 0); apb(1, OFS_VECTOR1, {24'h0, v1}, 0);
      apb(0, OFS_VECTOR0, {24'h0, v0}, 0); apb(0, OFS_VECTOR1, {24'h0, v1}, 0);
      apb(0, OFS_STATUS, 32'h0000_1f00, 0);
      apb(0, 8'h0c, 32'h0, 1);  // Unmapped word refused
      repeat (400) begin @(posedge clock_i); step(); end
      // Bidirectional port A of controller 0, then with the output strap fitted
      for (int i = 0; i < 4; i++) begin
         @(posedge clock_i);
         handshake_option_straps_i <= (i == 3) ? 18'h0006c : 18'h00064;
         @(posedge clock_i);
         port_a_strobe_i <= {1'b1, ~i[0]}; port_b_strobe_i <= {1'b1, i[0]};
         @(posedge clock_i);
         port_a_strobe_i <= 2'b11; port_b_strobe_i <= 2'b11;
         repeat (4) @(posedge clock_i);
         note((i == 1) ? 33'h200 : 33'h800, 33'ha00, 1);
      end
      repeat (3) @(posedge clock_i);
      complete_run();
   end
   // Hang guard, far beyond the expected run of some 460 cycles
   initial begin
      #20000;
      error_cnt++;
      complete_run();
   end
endmodule
bind card_glue card_glue_sva i_card_glue_sva (.*);
